// ===== verilog/valve_diag_pkg.sv
// package: constants, types and layouts of the valve fieldbus diagnostics
// assumes a 200 MHz sys_clk and a 20-byte cyclic process image per direction
package valve_diag_pkg;
	localparam int          CLK_HZ      = 200_000_000;
	localparam int          HOUR_S      = 3600;
	localparam longint      HOUR_CYCLES = longint'(HOUR_S) * longint'(CLK_HZ);
	localparam int          PRE_W       = 40;
	localparam logic [31:0] HOURS_MAX   = 32'h0098_9680; // 10000000
	localparam logic [31:0] HOURS_RST   = 32'h0000_0000;

	// parameter indices
	localparam logic [15:0] IDX_PWR_HOURS  = 16'h0064;
	localparam logic [15:0] IDX_SOLA_HOURS = 16'h0065;
	localparam logic [15:0] IDX_SOLB_HOURS = 16'h0066;
	localparam logic [15:0] IDX_ERRORS     = 16'h00C8;
	localparam logic [15:0] IDX_WARNINGS   = 16'h00C9;
	localparam logic [15:0] IDX_REQ_FLAGS  = 16'h012C;
	localparam logic [15:0] IDX_CFG        = 16'h012D;
	localparam logic [15:0] IDX_IP_ADDR    = 16'h0136;
	localparam logic [15:0] IDX_NET_MASK   = 16'h0137;
	localparam logic [15:0] IDX_GATEWAY    = 16'h0138;
	localparam logic [15:0] IDX_NET_NAME   = 16'h0139;

	// request flag and config bit positions
	localparam int RF_APPLY     = 0;
	localparam int RF_SAVE      = 1;
	localparam int CFG_BUS_EN   = 0;
	localparam int CFG_SENS_PWR = 1;
	localparam logic [31:0] NET_RST = 32'h0000_0000;

	// error bitmap positions
	localparam int EB_UV_PWR  = 0;
	localparam int EB_OV_PWR  = 1;
	localparam int EB_R0_LO   = 2;
	localparam int EB_R0_HI   = 3;
	localparam int EB_R1_LO   = 4;
	localparam int EB_R1_HI   = 5;
	localparam int EB_F0_LO   = 6;
	localparam int EB_F0_HI   = 7;
	localparam int EB_F1_LO   = 8;
	localparam int EB_F1_HI   = 9;
	localparam int EB_OPEN1   = 16;
	localparam int EB_OPEN2   = 17;
	localparam int EB_SHORT1  = 18;
	localparam int EB_SHORT2  = 19;
	localparam int EB_OVL1    = 20;
	localparam int EB_OVL2    = 21;
	localparam int EB_CPU_HOT = 23;
	localparam int EB_BR_HOT  = 24;

	// process image layout (byte offsets)
	localparam int          PD_BYTES  = 20;
	localparam logic [7:0]  PD_LEN    = 8'h14;
	localparam int          PD_CTRL   = 8;
	localparam int          PD_REF    = 10;
	localparam int          PD_STAT   = 8;
	localparam int          PD_MON    = 10;
	localparam int          PD_SSI    = 12;
	localparam int          PD_AN1    = 16;
	localparam int          PD_AN2    = 18;
	localparam logic [15:0] CW_DISABLE = 16'h0000;
	localparam logic [15:0] CW_ENABLE  = 16'h0007;
	localparam logic [15:0] SW_ERROR   = 16'h0000;
	localparam logic [15:0] SW_READY   = 16'h0008;
	localparam logic [15:0] SW_ENABLED = 16'h000F;
	localparam logic [15:0] REF_RST    = 16'h0000;

	typedef enum logic [2:0] {
		ST_READY   = 3'b001,
		ST_ENABLED = 3'b010,
		ST_ERROR   = 3'b100
	} valve_state_e;

	typedef struct packed {
		logic uv_pwr;  logic ov_pwr;
		logic ref0_lo; logic ref0_hi;
		logic ref1_lo; logic ref1_hi;
		logic fb0_lo;  logic fb0_hi;
		logic fb1_lo;  logic fb1_hi;
		logic open1;   logic open2;
		logic short1;  logic short2;
		logic ovl1;    logic ovl2;
		logic cpu_hot; logic bridge_hot;
	} fault_s;

	typedef struct packed {
		logic [31:0] name;
		logic [31:0] gateway;
		logic [31:0] mask;
		logic [31:0] ip;
		logic        sens_pwr;
		logic        bus_en;
	} cfg_s;
endpackage : valve_diag_pkg

// ===== verilog/rise_detect.sv
// rising edge detector for one request flag bit
// assumes the flag level is synchronous to sys_clk
`timescale 1ns/1ps
module rise_detect (
	input  wire logic sys_clk, // system clock
	input  wire logic arst_n,  // async reset, active low
	input  wire logic level,   // flag level
	output logic      pulse    // one cycle on 0 to 1
);
	logic prev_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= level;
		end
	end

	assign pulse = level & ~prev_reg;
endmodule : rise_detect

// ===== verilog/hour_counter.sv
// saturating operating-hour counter with cycle prescaler
// assumes run is synchronous; CYC is cycles per hour
`timescale 1ns/1ps
module hour_counter #(
	parameter longint CYC = valve_diag_pkg::HOUR_CYCLES,
	parameter int     W   = valve_diag_pkg::PRE_W
) (
	input  wire logic        sys_clk, // system clock
	input  wire logic        arst_n,  // async reset, active low
	input  wire logic        run,     // count while high
	output logic      [31:0] hours    // whole hours counted
);
	logic [W-1:0] pre_reg;
	logic [31:0]  hours_reg;
	logic         wrap;

	assign wrap  = run && (pre_reg == W'(CYC - 1));
	assign hours = hours_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_reg   <= '0;
			hours_reg <= valve_diag_pkg::HOURS_RST;
		end else begin
			if (wrap) begin
				pre_reg <= '0;
			end else if (run) begin
				pre_reg <= pre_reg + W'(1);
			end
			if (wrap && hours_reg < valve_diag_pkg::HOURS_MAX) begin
				hours_reg <= hours_reg + 32'h0000_0001;
			end
		end
	end
endmodule : hour_counter

// ===== verilog/valve_fieldbus_diag.sv
// fieldbus process data, parameter access and valve state machine
// assumes parameter and process ports are driven synchronously by the
// fieldbus stack; nonvolatile store is external, fed by nv_save
//
// Notes on behaviour
// - powered hours counter, index 100, saturates 10000000
// - solenoid hour counters at 101, 102
// - error bitmap 200, warning bitmap 201
// - pending parameters apply on flag bit0 rise
// - flag bit1 rise saves parameters nonvolatile
// - power-stage under/overvoltage in bits 0, 1
// - reference 0/1 range errors bits 2-5
// - feedback 0/1 range errors bits 6-9
// - open solenoid 16-17, short circuit 18-19
// - overload 20-21, overtemperature 23-24, rest zero
// - cyclic image is 20 bytes each way
// - alarm on process image size mismatch
// - control word bytes 8-9, reference 10-11
// - reference and monitor signed 16-bit, 0.01%
// - status, monitor, ssi, analogue input layout
// - enable pin drives enabled, ready, error
// - control word 0000 disables, resets errors
// - control word 0007 enables if error-free
// - status word 00 error, 08 ready, 0F
// - ssi active only after saved power, restart
// - network settings zero until assigned, persisted
`timescale 1ns/1ps
module valve_fieldbus_diag #(
	parameter longint CYC_PER_HOUR = valve_diag_pkg::HOUR_CYCLES,
	parameter bit     TWO_SOLENOID = 1'b1
) (
	input  wire logic                   sys_clk,      // system clock
	input  wire logic                   arst_n,       // async reset
	input  wire logic                   par_req,      // parameter access
	input  wire logic                   par_we,       // 1 write, 0 read
	input  wire logic            [15:0] par_index,    // parameter index
	input  wire logic            [31:0] par_wdata,    // write data
	output logic                 [31:0] par_rdata,    // read data
	output logic                        par_ack,      // access done
	output logic                        par_err,      // bad index/RO
	input  wire logic           [159:0] pd_rx,        // master to valve
	input  wire logic                   pd_rx_valid,  // new image
	input  wire logic             [7:0] pd_rx_len,    // rx image bytes
	input  wire logic             [7:0] pd_tx_len,    // tx image bytes
	output logic                [159:0] pd_tx,        // valve to master
	output logic                        pd_alarm,     // size mismatch
	input  wire logic                   enable_pin,   // external enable
	input  wire valve_diag_pkg::fault_s faults,       // fault sources
	input  wire logic            [31:0] warnings,     // warning sources
	input  wire logic                   sol_a_on,     // solenoid a on
	input  wire logic                   sol_b_on,     // solenoid b on
	input  wire logic            [15:0] monitor,      // spool monitor
	input  wire logic            [31:0] ssi_value,    // ssi reading
	input  wire logic            [15:0] an1_value,    // transducer 1
	input  wire logic            [15:0] an2_value,    // transducer 2
	input  wire valve_diag_pkg::cfg_s   nv_cfg,       // stored config
	output valve_diag_pkg::cfg_s        active_cfg,   // applied config
	output logic                        nv_save,      // save pulse
	output logic                        ssi_active,   // ssi enabled
	output logic                 [15:0] reference,    // applied ref
	output logic                        drive_en      // solenoid drive
);
	valve_diag_pkg::cfg_s         pend_reg, act_reg;
	valve_diag_pkg::valve_state_e state_reg, state_next;
	logic [31:0]  err_reg, err_next, warn_reg, flags_reg;
	logic [31:0]  hrs_pwr, hrs_a, hrs_b, rd_next;
	logic [15:0]  cw_reg, ref_reg, sw_next;
	logic [159:0] tx_next;
	logic         boot_reg, ssi_reg, alarm_reg, ack_reg, perr_reg;
	logic         apply_p, save_p, err_any, rd_hit, wr_hit;
	logic         cw_dis, cw_ena;
	logic [31:0]  rd_data_reg;

	hour_counter #(.CYC(CYC_PER_HOUR)) u_hrs_pwr (
		.sys_clk(sys_clk), .arst_n(arst_n), .run(1'b1), .hours(hrs_pwr));
	hour_counter #(.CYC(CYC_PER_HOUR)) u_hrs_a (
		.sys_clk(sys_clk), .arst_n(arst_n), .run(sol_a_on), .hours(hrs_a));
	hour_counter #(.CYC(CYC_PER_HOUR)) u_hrs_b (
		.sys_clk(sys_clk), .arst_n(arst_n),
		.run(sol_b_on & TWO_SOLENOID), .hours(hrs_b));

	rise_detect u_apply (.sys_clk(sys_clk), .arst_n(arst_n),
		.level(flags_reg[valve_diag_pkg::RF_APPLY]), .pulse(apply_p));
	rise_detect u_save (.sys_clk(sys_clk), .arst_n(arst_n),
		.level(flags_reg[valve_diag_pkg::RF_SAVE]), .pulse(save_p));

	always_comb begin
		err_next = '0;
		err_next[valve_diag_pkg::EB_UV_PWR]  = faults.uv_pwr;
		err_next[valve_diag_pkg::EB_OV_PWR]  = faults.ov_pwr;
		err_next[valve_diag_pkg::EB_R0_LO]   = faults.ref0_lo;
		err_next[valve_diag_pkg::EB_R0_HI]   = faults.ref0_hi;
		err_next[valve_diag_pkg::EB_R1_LO]   = faults.ref1_lo;
		err_next[valve_diag_pkg::EB_R1_HI]   = faults.ref1_hi;
		err_next[valve_diag_pkg::EB_F0_LO]   = faults.fb0_lo;
		err_next[valve_diag_pkg::EB_F0_HI]   = faults.fb0_hi;
		err_next[valve_diag_pkg::EB_F1_LO]   = faults.fb1_lo;
		err_next[valve_diag_pkg::EB_F1_HI]   = faults.fb1_hi;
		err_next[valve_diag_pkg::EB_OPEN1]   = faults.open1;
		err_next[valve_diag_pkg::EB_OPEN2]   = faults.open2;
		err_next[valve_diag_pkg::EB_SHORT1]  = faults.short1;
		err_next[valve_diag_pkg::EB_SHORT2]  = faults.short2;
		err_next[valve_diag_pkg::EB_OVL1]    = faults.ovl1;
		err_next[valve_diag_pkg::EB_OVL2]    = faults.ovl2;
		err_next[valve_diag_pkg::EB_CPU_HOT] = faults.cpu_hot;
		err_next[valve_diag_pkg::EB_BR_HOT]  = faults.bridge_hot;
	end

	assign err_any = (err_reg != '0) || alarm_reg;
	assign cw_dis  = cw_reg == valve_diag_pkg::CW_DISABLE;
	assign cw_ena  = cw_reg == valve_diag_pkg::CW_ENABLE;

	always_comb begin
		state_next = state_reg;
		if (act_reg.bus_en) begin
			if (cw_dis) begin
				state_next = err_any ? valve_diag_pkg::ST_ERROR
				                     : valve_diag_pkg::ST_READY;
			end else if (cw_ena) begin
				state_next = err_any ? valve_diag_pkg::ST_ERROR
				                     : valve_diag_pkg::ST_ENABLED;
			end else if (err_any) begin
				state_next = valve_diag_pkg::ST_ERROR;
			end
		end else if (err_any) begin
			state_next = valve_diag_pkg::ST_ERROR;
		end else begin
			state_next = enable_pin ? valve_diag_pkg::ST_ENABLED
			                        : valve_diag_pkg::ST_READY;
			if (state_reg == valve_diag_pkg::ST_ERROR && enable_pin) begin
				state_next = valve_diag_pkg::ST_ERROR;
			end
		end
	end

	always_comb begin
		case (state_reg)
			valve_diag_pkg::ST_READY:   sw_next = valve_diag_pkg::SW_READY;
			valve_diag_pkg::ST_ENABLED: sw_next = valve_diag_pkg::SW_ENABLED;
			valve_diag_pkg::ST_ERROR:   sw_next = valve_diag_pkg::SW_ERROR;
			default:                    sw_next = valve_diag_pkg::SW_ERROR;
		endcase
	end

	// tx image, low byte first within a field
	always_comb begin
		tx_next = '0;
		tx_next[valve_diag_pkg::PD_STAT*8 +: 16] = sw_next;
		tx_next[valve_diag_pkg::PD_MON*8 +: 16]  = monitor;
		tx_next[valve_diag_pkg::PD_SSI*8 +: 32]  = ssi_reg ? ssi_value : '0;
		tx_next[valve_diag_pkg::PD_AN1*8 +: 16]  = an1_value;
		tx_next[valve_diag_pkg::PD_AN2*8 +: 16]  = an2_value;
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_next = '0;
		case (par_index)
			valve_diag_pkg::IDX_PWR_HOURS:  rd_next = hrs_pwr;
			valve_diag_pkg::IDX_SOLA_HOURS: rd_next = hrs_a;
			valve_diag_pkg::IDX_SOLB_HOURS: begin
				rd_next = TWO_SOLENOID ? hrs_b : '0;
				rd_hit  = TWO_SOLENOID;
			end
			valve_diag_pkg::IDX_ERRORS:     rd_next = err_reg;
			valve_diag_pkg::IDX_WARNINGS:   rd_next = warn_reg;
			valve_diag_pkg::IDX_REQ_FLAGS:  rd_next = flags_reg;
			valve_diag_pkg::IDX_CFG:
				rd_next = {30'h0, pend_reg.sens_pwr, pend_reg.bus_en};
			valve_diag_pkg::IDX_IP_ADDR:    rd_next = pend_reg.ip;
			valve_diag_pkg::IDX_NET_MASK:   rd_next = pend_reg.mask;
			valve_diag_pkg::IDX_GATEWAY:    rd_next = pend_reg.gateway;
			valve_diag_pkg::IDX_NET_NAME:   rd_next = pend_reg.name;
			default:                        rd_hit  = 1'b0;
		endcase
	end

	assign wr_hit = par_index == valve_diag_pkg::IDX_REQ_FLAGS
		|| par_index == valve_diag_pkg::IDX_CFG
		|| par_index == valve_diag_pkg::IDX_IP_ADDR
		|| par_index == valve_diag_pkg::IDX_NET_MASK
		|| par_index == valve_diag_pkg::IDX_GATEWAY
		|| par_index == valve_diag_pkg::IDX_NET_NAME;

	// parameter access answer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg     <= 1'b0;
			perr_reg    <= 1'b0;
			rd_data_reg <= '0;
		end else begin
			ack_reg  <= par_req;
			perr_reg <= par_req && (par_we ? !wr_hit : !rd_hit);
			if (par_req && !par_we) begin
				rd_data_reg <= rd_next;
			end
		end
	end

	// pending writes; apply copies pending to active
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= '0;
			pend_reg  <= '0;
			act_reg   <= '0;
			boot_reg  <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
			if (boot_reg) begin
				pend_reg <= nv_cfg;
				act_reg  <= nv_cfg;
			end else if (apply_p) begin
				act_reg <= pend_reg;
			end
			if (par_req && par_we && !boot_reg) begin
				case (par_index)
					valve_diag_pkg::IDX_REQ_FLAGS: flags_reg <= par_wdata;
					valve_diag_pkg::IDX_CFG: begin
						pend_reg.bus_en <= par_wdata[valve_diag_pkg::CFG_BUS_EN];
						pend_reg.sens_pwr <=
							par_wdata[valve_diag_pkg::CFG_SENS_PWR];
					end
					valve_diag_pkg::IDX_IP_ADDR:  pend_reg.ip      <= par_wdata;
					valve_diag_pkg::IDX_NET_MASK: pend_reg.mask    <= par_wdata;
					valve_diag_pkg::IDX_GATEWAY:  pend_reg.gateway <= par_wdata;
					valve_diag_pkg::IDX_NET_NAME: pend_reg.name    <= par_wdata;
					default: ;
				endcase
			end
		end
	end

	// ssi power caught from stored config at start only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ssi_reg <= 1'b0;
		end else if (boot_reg) begin
			ssi_reg <= nv_cfg.sens_pwr;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cw_reg    <= valve_diag_pkg::CW_DISABLE;
			ref_reg   <= valve_diag_pkg::REF_RST;
			alarm_reg <= 1'b0;
			err_reg   <= '0;
			warn_reg  <= '0;
			state_reg <= valve_diag_pkg::ST_READY;
			pd_tx     <= '0;
		end else begin
			alarm_reg <= pd_rx_len != valve_diag_pkg::PD_LEN
				|| pd_tx_len != valve_diag_pkg::PD_LEN;
			if (pd_rx_valid) begin
				cw_reg  <= pd_rx[valve_diag_pkg::PD_CTRL*8 +: 16];
				ref_reg <= pd_rx[valve_diag_pkg::PD_REF*8 +: 16];
			end
			err_reg   <= err_next;
			warn_reg  <= warnings;
			state_reg <= state_next;
			pd_tx     <= tx_next;
		end
	end

	assign par_ack    = ack_reg;
	assign par_err    = perr_reg;
	assign par_rdata  = rd_data_reg;
	assign pd_alarm   = alarm_reg;
	assign active_cfg = act_reg;
	assign ssi_active = ssi_reg;
	assign reference  = ref_reg;
	assign nv_save    = save_p;
	assign drive_en   = state_reg == valve_diag_pkg::ST_ENABLED;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	status_error_a:
		assert property (state_reg == valve_diag_pkg::ST_ERROR
		|=> pd_tx[valve_diag_pkg::PD_STAT*8 +: 16] == 16'h0000)
		else $error("status word not 00 in error");
	status_enable_a:
		assert property (drive_en
		|=> pd_tx[valve_diag_pkg::PD_STAT*8 +: 16] == 16'h000F)
		else $error("status word not 0F when enabled");
	apply_edge_a:
		assert property ($rose(flags_reg[0]) && !boot_reg
		|=> act_reg == $past(pend_reg))
		else $error("pending config not applied");
	hold_no_edge_a:
		assert property (!apply_p && !boot_reg
		|=> $stable(act_reg))
		else $error("active config changed without edge");
	save_edge_a:
		assert property (nv_save
		|-> flags_reg[1] && !$past(flags_reg[1]))
		else $error("save pulse without rising bit1");
	size_alarm_a:
		assert property (pd_rx_len != 8'h14
		|=> pd_alarm)
		else $error("image size mismatch not alarmed");
	fault_error_a:
		assert property (faults.uv_pwr
		|=> err_reg[0] ##1 state_reg == valve_diag_pkg::ST_ERROR)
		else $error("undervoltage did not force error");
	unused_bits_a:
		assert property ((err_reg & 32'hFE40_FC00) == '0)
		else $error("unused error bit set");
	bus_enable_a:
		assert property (act_reg.bus_en && cw_ena && !err_any
		|=> drive_en)
		else $error("enable code did not enable");
	other_cw_a:
		assert property (act_reg.bus_en && !cw_ena && !cw_dis
		&& !err_any |=> $stable(state_reg))
		else $error("other control word changed state");
	ssi_gate_a:
		assert property (!ssi_active
		|=> pd_tx[valve_diag_pkg::PD_SSI*8 +: 32] == '0)
		else $error("ssi sent while inactive");
	disable_code_a:
		assert property (act_reg.bus_en && cw_dis
		|=> !drive_en)
		else $error("disable code left drive on");
	pin_enable_a:
		assert property (!act_reg.bus_en && enable_pin && !err_any
		&& state_reg == valve_diag_pkg::ST_READY |=> drive_en)
		else $error("enable pin did not enable");
	pin_drop_a:
		assert property (!act_reg.bus_en && !enable_pin
		|=> !drive_en)
		else $error("low enable pin left drive on");

	enable_seen_c: cover property (!drive_en ##1 drive_en);
	error_exit_c:  cover property (state_reg == valve_diag_pkg::ST_ERROR
		##1 state_reg == valve_diag_pkg::ST_READY);
	apply_seen_c:  cover property (apply_p);
	save_seen_c:   cover property (nv_save);
	bus_ready_c:   cover property (act_reg.bus_en && cw_dis
		##1 state_reg == valve_diag_pkg::ST_READY);
endmodule : valve_fieldbus_diag

// ===== sim/fieldbus_master.sv
// partner model: fieldbus master on the parameter and process ports
// assumes calls start after the design's boot cycle
`timescale 1ns/1ps
module fieldbus_master (
	input  wire logic         sys_clk,     // system clock
	input  wire logic         arst_n,      // async reset, active low
	output logic              par_req,     // parameter access
	output logic              par_we,      // write select
	output logic      [15:0]  par_index,   // parameter index
	output logic      [31:0]  par_wdata,   // write data
	input  wire logic [31:0]  par_rdata,   // read data
	input  wire logic         par_ack,     // access done
	input  wire logic         par_err,     // access refused
	output logic      [159:0] pd_rx,       // master to valve image
	output logic              pd_rx_valid, // image strobe
	output logic      [7:0]   pd_rx_len,   // rx image size
	output logic      [7:0]   pd_tx_len    // tx image size
);
	initial begin
		par_req     = 1'b0;
		par_we      = 1'b0;
		par_index   = 16'h0000;
		par_wdata   = 32'h00000000;
		pd_rx       = {20{8'hA5}};
		pd_rx_valid = 1'b0;
		pd_rx_len   = valve_diag_pkg::PD_LEN;
		pd_tx_len   = valve_diag_pkg::PD_LEN;
	end

	// one access: request pulse, answer within four edges
	task automatic access(input logic we, input logic [15:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		par_req   <= 1'b1;
		par_we    <= we;
		par_index <= idx;
		par_wdata <= wd;
		@(posedge sys_clk);
		par_req   <= 1'b0;
		par_index <= ~idx;
		par_wdata <= ~wd;
		n = 0;
		rd = 32'hXXXXXXXX;
		err = 1'bx;
		do begin
			@(posedge sys_clk);
			n++;
		end while (par_ack !== 1'b1 && n < 4);
		if (par_ack === 1'b1) begin
			rd = par_rdata;
			err = par_err;
		end
	endtask : access

	task automatic raise(input int b);
		logic [31:0] d;
		logic        e;
		access(1'b1, valve_diag_pkg::IDX_REQ_FLAGS, 32'h1 << b, d, e);
		access(1'b1, valve_diag_pkg::IDX_REQ_FLAGS, 32'h00000000, d, e);
	endtask : raise

	task automatic send_pd(input logic [15:0] cw, input logic [15:0] rf);
		@(posedge sys_clk);
		pd_rx[8*valve_diag_pkg::PD_CTRL +: 16] <= cw;
		pd_rx[8*valve_diag_pkg::PD_REF +: 16]  <= rf;
		pd_rx_valid <= 1'b1;
		@(posedge sys_clk);
		pd_rx_valid <= 1'b0;
	endtask : send_pd

	task automatic set_len(input logic [7:0] rx, input logic [7:0] tx);
		@(posedge sys_clk);
		pd_rx_len <= rx;
		pd_tx_len <= tx;
	endtask : set_len
endmodule : fieldbus_master

// ===== sim/testbench.sv
// self-checking bench for the valve fieldbus diagnostics block
// assumes the fieldbus_master partner model; ten cycles per hour
`timescale 1ns/1ps
module testbench;
	logic                   sys_clk, arst_n, par_req, par_we, par_ack;
	logic                   par_err, pd_rx_valid, pd_alarm, enable_pin;
	logic                   sol_a_on, sol_b_on, nv_save, ssi_active;
	logic                   drive_en;
	logic [15:0]            par_index, monitor, an1_value, an2_value;
	logic [15:0]            reference;
	logic [31:0]            par_wdata, par_rdata, warnings, ssi_value;
	logic [31:0]            v0, v1;
	logic                   e;
	logic [159:0]           pd_rx, pd_tx;
	logic [7:0]             pd_rx_len, pd_tx_len;
	valve_diag_pkg::fault_s faults;
	valve_diag_pkg::cfg_s   nv_cfg, active_cfg;
	int                     n_fail, n_checks, n_save;
	int epos[18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 16, 17, 18, 19, 20, 21,
		23, 24};
	logic [15:0] ro_idx[5] = '{valve_diag_pkg::IDX_PWR_HOURS,
		valve_diag_pkg::IDX_SOLA_HOURS, valve_diag_pkg::IDX_SOLB_HOURS,
		valve_diag_pkg::IDX_ERRORS, valve_diag_pkg::IDX_WARNINGS};

	valve_fieldbus_diag #(.CYC_PER_HOUR(10), .TWO_SOLENOID(1'b1))
	i_valve_fieldbus_diag (.sys_clk, .arst_n, .par_req, .par_we,
		.par_index, .par_wdata, .par_rdata, .par_ack, .par_err, .pd_rx,
		.pd_rx_valid, .pd_rx_len, .pd_tx_len, .pd_tx, .pd_alarm,
		.enable_pin, .faults, .warnings, .sol_a_on, .sol_b_on, .monitor,
		.ssi_value, .an1_value, .an2_value, .nv_cfg, .active_cfg, .nv_save,
		.ssi_active, .reference, .drive_en);

	fieldbus_master i_fieldbus_master (.sys_clk, .arst_n, .par_req,
		.par_we, .par_index, .par_wdata, .par_rdata, .par_ack, .par_err,
		.pd_rx, .pd_rx_valid, .pd_rx_len, .pd_tx_len);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) if (nv_save === 1'b1) n_save++;

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		give_verdict();
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// access and compare answer; data only on accepted reads
	task automatic acc(input logic we, input logic [15:0] idx,
		input logic [31:0] d, input logic eerr);
		i_fieldbus_master.access(we, idx, d, v0, e);
		chk($sformatf("error flag %h", idx), {31'h0, eerr}, {31'h0, e});
		if (!we && !eerr)
			chk($sformatf("index %h", idx), d, v0);
	endtask : acc

	task automatic stat(input logic [15:0] exp);
		repeat (4) @(posedge sys_clk);
		chk("status word", {16'h0, exp}, {16'h0, pd_tx[64 +: 16]});
		chk("drive", {31'h0, exp == valve_diag_pkg::SW_ENABLED},
			{31'h0, drive_en});
	endtask : stat

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial begin
		n_fail = 0; n_checks = 0; n_save = 0;
		arst_n = 1'b0; enable_pin = 1'b0; faults = '0;
		warnings = 32'h00000000; sol_a_on = 1'b0; sol_b_on = 1'b0;
		monitor = 16'hD8F0; ssi_value = 32'h12345678;
		an1_value = 16'h0A11; an2_value = 16'h0B22; nv_cfg = '0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 5; i++)
			acc(1'b0, ro_idx[i], 32'h00000000, 1'b0);
		for (int i = 0; i < 5; i++)
			acc(1'b1, ro_idx[i], 32'hFFFFFFFF, 1'b1);
		for (int i = 1; i < 5; i++)
			acc(1'b0, ro_idx[i], 32'h00000000, 1'b0);
		acc(1'b0, 16'h0001, 32'h00000000, 1'b1);
		for (int i = 0; i < 3; i++)
			acc(1'b0, valve_diag_pkg::IDX_IP_ADDR + 16'(i), 32'h0, 1'b0);
		i_fieldbus_master.access(1'b0, ro_idx[0], 32'h0, v1, e);
		repeat (97) @(posedge sys_clk);
		i_fieldbus_master.access(1'b0, ro_idx[0], 32'h0, v0, e);
		chk("powered hours step", 32'h0000000A, v0 - v1);
		sol_a_on <= 1'b1;
		repeat (50) @(posedge sys_clk);
		sol_a_on <= 1'b0;
		sol_b_on <= 1'b1;
		repeat (30) @(posedge sys_clk);
		sol_b_on <= 1'b0;
		acc(1'b0, ro_idx[1], 32'h00000005, 1'b0);
		acc(1'b0, ro_idx[2], 32'h00000003, 1'b0);
		$display("test registers finished");
		for (int k = 0; k < 18; k++) begin
			faults <= valve_diag_pkg::fault_s'(18'h20000 >> k);
			repeat (3) @(posedge sys_clk);
			acc(1'b0, ro_idx[3], 32'h1 << epos[k], 1'b0);
		end
		faults <= '0;
		warnings <= 32'h80000001;
		repeat (3) @(posedge sys_clk);
		acc(1'b0, ro_idx[4], 32'h80000001, 1'b0);
		acc(1'b0, ro_idx[3], 32'h00000000, 1'b0);
		$display("test bitmaps finished");
		chk("reserved", 32'h0, pd_tx[31:0] | pd_tx[63:32]);
		chk("monitor", 32'h0000D8F0, {16'h0, pd_tx[80 +: 16]});
		chk("ssi off", 32'h0, pd_tx[96 +: 32]);
		chk("an1", 32'h00000A11, {16'h0, pd_tx[128 +: 16]});
		chk("an2", 32'h00000B22, {16'h0, pd_tx[144 +: 16]});
		i_fieldbus_master.set_len(8'h13, valve_diag_pkg::PD_LEN);
		repeat (3) @(posedge sys_clk);
		chk("alarm rx", 32'h1, {31'h0, pd_alarm});
		i_fieldbus_master.set_len(valve_diag_pkg::PD_LEN, 8'h15);
		repeat (3) @(posedge sys_clk);
		chk("alarm tx", 32'h1, {31'h0, pd_alarm});
		i_fieldbus_master.set_len(valve_diag_pkg::PD_LEN, 8'h14);
		repeat (3) @(posedge sys_clk);
		chk("alarm off", 32'h0, {31'h0, pd_alarm});
		$display("test image finished");
		stat(valve_diag_pkg::SW_READY);
		enable_pin <= 1'b1;
		stat(valve_diag_pkg::SW_ENABLED);
		faults.ovl1 <= 1'b1;
		stat(valve_diag_pkg::SW_ERROR);
		faults.ovl1 <= 1'b0;
		stat(valve_diag_pkg::SW_ERROR);
		enable_pin <= 1'b0;
		stat(valve_diag_pkg::SW_READY);
		$display("test pin mode finished");
		acc(1'b1, valve_diag_pkg::IDX_CFG, 32'h00000001, 1'b0);
		repeat (3) @(posedge sys_clk);
		chk("bus enable pending", 32'h0, {31'h0, active_cfg.bus_en});
		i_fieldbus_master.raise(valve_diag_pkg::RF_APPLY);
		chk("bus enable applied", 32'h1, {31'h0, active_cfg.bus_en});
		chk("no save", 32'h0, n_save);
		i_fieldbus_master.raise(valve_diag_pkg::RF_SAVE);
		chk("one save", 32'h1, n_save);
		i_fieldbus_master.send_pd(valve_diag_pkg::CW_ENABLE, 16'hD8F0);
		stat(valve_diag_pkg::SW_ENABLED);
		chk("reference", 32'h0000D8F0, {16'h0, reference});
		i_fieldbus_master.send_pd(16'h0003, 16'h2710);
		stat(valve_diag_pkg::SW_ENABLED);
		chk("reference max", 32'h00002710, {16'h0, reference});
		i_fieldbus_master.send_pd(valve_diag_pkg::CW_DISABLE, 16'h0000);
		stat(valve_diag_pkg::SW_READY);
		faults.short1 <= 1'b1;
		i_fieldbus_master.send_pd(valve_diag_pkg::CW_ENABLE, 16'h0000);
		stat(valve_diag_pkg::SW_ERROR);
		i_fieldbus_master.send_pd(16'h0003, 16'h0000);
		faults.short1 <= 1'b0;
		stat(valve_diag_pkg::SW_ERROR);
		i_fieldbus_master.send_pd(valve_diag_pkg::CW_DISABLE, 16'h0000);
		stat(valve_diag_pkg::SW_READY);
		$display("test bus mode finished");
		nv_cfg.sens_pwr <= 1'b1;
		arst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("ssi active", 32'h1, {31'h0, ssi_active});
		chk("ssi value", 32'h12345678, pd_tx[96 +: 32]);
		$display("test restart finished");
		give_verdict();
	end
endmodule : testbench
